// ### brf_pkg.sv
// package: constants, types and layouts for the banked register file with ring spill
package brf_pkg;

  // ***************************************************************
  // register offsets on the plain register port
  // ***************************************************************
  localparam logic [3:0] ADDR_MODE     = 4'h0;  // bank mode register
  localparam logic [3:0] ADDR_GBANK    = 4'h1;  // global bank select
  localparam logic [3:0] ADDR_CBANK    = 4'h2;  // current ring bank number
  localparam logic [3:0] ADDR_VLIMIT   = 4'h3;  // valid ring bank limit
  localparam logic [3:0] ADDR_SPILL    = 4'h4;  // spill pointer
  localparam logic [3:0] ADDR_STATUS   = 4'h5;  // engine status

  // ***************************************************************
  // bank mode register fields and reset values
  // ***************************************************************
  localparam int         MODE_CNT_LO   = 0;     // bank_count_select_lo
  localparam int         MODE_CNT_HI   = 1;     // bank_count_select_hi
  localparam int         MODE_RING     = 2;     // bank_mode_select
  localparam int         MODE_PROTECT  = 3;     // bank_protect
  localparam int         MODE_RAM_EN   = 4;     // internal_ram_enable
  localparam logic [4:0] MODE_RESET    = 5'h10; // ram enabled, global 2-bank
  localparam logic [7:0] GBANK_RESET   = 8'h00;
  localparam logic [7:0] CBANK_RESET   = 8'h00;
  localparam logic [7:0] VLIMIT_RESET  = 8'h00;
  localparam logic [31:0] SPILL_RESET  = 32'h00000000;

  // ***************************************************************
  // geometry
  // ***************************************************************
  localparam int          NUM_REGS     = 16;
  localparam int          NUM_SLOTS    = 32;           // 16 global + 8 ring, padded
  localparam int          RING_BASE    = 16;           // ring bank n lives at slot 16+n
  localparam logic [31:0] REG_BYTES    = 32'h00000004; // pointer step per register
  localparam logic [10:0] RAM_BYTES    = 11'h400;      // 1024 bytes of internal ram
  localparam logic [10:0] BANK_BYTES   = 11'h040;      // 64 bytes per bank

  // ***************************************************************
  // types
  // ***************************************************************
  typedef enum logic [5:0] {
    ST_IDLE  = 6'h01,
    ST_STORE = 6'h02,
    ST_FETCH = 6'h04,
    ST_LOAD  = 6'h08,
    ST_COPY  = 6'h10,
    ST_PUSHG = 6'h20
  } brf_state_type;

  typedef enum logic [2:0] {
    OP_NONE    = 3'h0,
    OP_PUSH_CH = 3'h1,  // push_change_global_bank
    OP_PULL    = 3'h2,  // pull_global_bank
    OP_ADVANCE = 3'h3,  // ring_advance
    OP_RETREAT = 3'h4   // ring_retreat
  } brf_op_type;

  // one port of register operand: bank class and register number
  typedef struct packed {
    logic [1:0] sel;    // 0 global, 1 current ring, 2 previous ring
    logic [3:0] num;
  } brf_operand_type;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } brf_mem_type;

  localparam logic [1:0] SEL_GLOBAL  = 2'h0;
  localparam logic [1:0] SEL_CURRENT = 2'h1;
  localparam logic [1:0] SEL_PREV    = 2'h2;

endpackage

// ### brf_bank_ram.sv
// bank storage: all register banks as one array, one write port, two read ports
`timescale 1ns/1ps
`default_nettype none
module brf_bank_ram (
  input  wire logic        clock,
  input  wire logic        ce,
  input  wire logic        we,
  input  wire logic [8:0]  waddr,
  input  wire logic [31:0] wdata,
  input  wire logic [8:0]  raddr_a,
  output logic      [31:0] rdata_a,
  input  wire logic [8:0]  raddr_b,
  output logic      [31:0] rdata_b
);

  logic [31:0] mem [0:511];

  // registers are not initialised at reset, so no reset on the array
  always_ff @(posedge clock) begin
    if (ce && we) begin
      mem[waddr] <= wdata;
    end
  end

  // combinational reads keep the sequencer operand path single-cycle
  assign rdata_a = mem[raddr_a];
  assign rdata_b = mem[raddr_b];

endmodule
`default_nettype wire

// ### brf_addr_map.sv
// internal ram data window decoder: routes a data address to ram or external
`timescale 1ns/1ps
`default_nettype none
module brf_addr_map (
  input  wire logic [4:0]  mode,
  input  wire logic        in_ram_range,
  input  wire logic [10:0] offset,
  output logic             to_internal,
  output logic             to_external,
  output logic [10:0]      free_bytes
);

  logic [10:0] bank_area;

  // banks in use depend on mode; ring mode takes the whole ram, 8 global plus 8 ring with count select 0
  always_comb begin
    bank_area = brf_pkg::RAM_BYTES;
    if (mode[brf_pkg::MODE_RING]) begin
      bank_area = brf_pkg::RAM_BYTES;
    end else begin
      case (mode[brf_pkg::MODE_CNT_HI:brf_pkg::MODE_CNT_LO])
        2'h0:    bank_area = brf_pkg::BANK_BYTES << 1;
        2'h1:    bank_area = brf_pkg::BANK_BYTES << 2;
        2'h2:    bank_area = brf_pkg::BANK_BYTES << 3;
        default: bank_area = brf_pkg::RAM_BYTES;
      endcase
    end
  end

  // 2/4/8 bank modes leave 896/768/512 bytes
  assign free_bytes  = brf_pkg::RAM_BYTES - bank_area;
  // data use only with ram enabled and protection clear
  assign to_internal = in_ram_range && mode[brf_pkg::MODE_RAM_EN]
                       && !mode[brf_pkg::MODE_PROTECT] && (offset < free_bytes);
  // ram disabled sends the window to external memory
  assign to_external = in_ram_range && !mode[brf_pkg::MODE_RAM_EN];

endmodule
`default_nettype wire

// ### brf_core.sv
// banked register file controller with global switching and ring spill/fill
//
// Our own choices: the plain strobed port and the address map.
`timescale 1ns/1ps
`default_nettype none
module brf_core (
  input  wire logic                     clock,
  input  wire logic                     rst,
  input  wire logic                     ce,
  // register port
  input  wire logic [3:0]               reg_addr,
  input  wire logic [31:0]              reg_wdata,
  input  wire logic                     reg_wr,
  input  wire logic                     reg_rd,
  output logic      [31:0]              reg_rdata,
  // sequencer register operands
  input  wire brf_pkg::brf_operand_type op_a,
  output logic      [31:0]              op_a_data,
  input  wire brf_pkg::brf_operand_type op_w,
  input  wire logic                     op_we,
  input  wire logic [31:0]              op_wdata,
  // bank instructions
  input  wire brf_pkg::brf_op_type      cmd,
  input  wire logic                     cmd_valid,
  input  wire logic                     cmd_use_reg,
  input  wire logic [3:0]               cmd_imm,
  input  wire logic [3:0]               cmd_reg,
  input  wire logic [15:0]              cmd_copy_mask,
  input  wire logic                     supervisor,
  output logic                          cmd_busy,
  output logic                          priv_fault,
  // memory stack bus
  input  wire logic [31:0]              supervisor_stack_pointer,
  output brf_pkg::brf_mem_type          mem_out,
  input  wire logic                     mem_ack,
  input  wire logic [31:0]              mem_rdata,
  output logic                          ssp_dec,
  output logic                          ssp_inc,
  // data window decode
  input  wire logic                     data_in_ram,
  input  wire logic [10:0]              data_offset,
  output logic                          data_internal,
  output logic                          data_external
);

  // ***************************************************************
  // state
  // ***************************************************************
  logic [4:0]  mode_r;
  logic [7:0]  gbank_r;
  logic [7:0]  cbank_r;
  logic [7:0]  vlimit_r;
  logic [31:0] spill_r;
  brf_pkg::brf_state_type state_r;
  brf_pkg::brf_op_type    op_r;
  logic [3:0]  idx_r;
  logic [15:0] mask_r;
  logic [4:0]  slot_r;        // bank slot being spilled or filled
  logic [3:0]  old_gbank_r;
  logic [7:0]  new_gbank_r;
  logic [15:0] copy_r;
  logic [31:0] ram_rb;
  logic        ram_we;
  logic [8:0]  ram_wa;
  logic [31:0] ram_wd;
  logic [8:0]  ram_rb_a;

  // ***************************************************************
  // decoding helpers
  // ***************************************************************
  // global bank number masked to the valid bits of the mode
  function automatic logic [3:0] gmask(input logic [4:0] m, input logic [7:0] g);
    logic [3:0] r;
    r = g[3:0];
    case ({m[brf_pkg::MODE_RING], m[brf_pkg::MODE_CNT_HI:brf_pkg::MODE_CNT_LO]})
      3'h0:       r = {3'h0, g[0]};
      3'h1:       r = {2'h0, g[1:0]};
      3'h2, 3'h4: r = {1'b0, g[2:0]};            // ring mode with count select 0 keeps eight globals
      default:    r = g[3:0];
    endcase
    return r;
  endfunction

  // storage address of a register in a bank slot, 16 per bank
  function automatic logic [8:0] slot_addr(input logic [4:0] s, input logic [3:0] n);
    return {s, n};
  endfunction

  // operand class picks the bank
  function automatic logic [8:0] opnd_addr(input brf_pkg::brf_operand_type o,
                                           input logic [4:0] m, input logic [7:0] g,
                                           input logic [7:0] c);
    logic [2:0] rb;
    rb = (o.sel == brf_pkg::SEL_PREV) ? c[2:0] - 3'h1 : c[2:0];
    if (o.sel == brf_pkg::SEL_GLOBAL || !m[brf_pkg::MODE_RING]) begin
      return slot_addr({1'b0, gmask(m, g)}, o.num);
    end
    return slot_addr(5'(brf_pkg::RING_BASE) + {2'h0, rb}, o.num);
  endfunction

  wire logic cmd_priv = (cmd == brf_pkg::OP_PUSH_CH) || (cmd == brf_pkg::OP_PULL);
  wire logic idle     = (state_r == brf_pkg::ST_IDLE);
  wire logic take     = ce && cmd_valid && idle;
  wire logic [3:0] next_idx = idx_r + 4'h1;
  // register 15 is always in the list
  wire logic [15:0] eff_mask = mask_r | 16'h8000;
  // ring slot named by the valid limit: the bank an overflow spills
  wire logic [4:0]  vslot    = 5'(brf_pkg::RING_BASE) + {2'h0, vlimit_r[2:0]};
  brf_bank_ram u_ram (
    .clock   (clock),
    .ce      (ce),
    .we      (ram_we),
    .waddr   (ram_wa),
    .wdata   (ram_wd),
    .raddr_a (opnd_addr(op_a, mode_r, gbank_r, cbank_r)),
    .rdata_a (op_a_data),
    .raddr_b (ram_rb_a),
    .rdata_b (ram_rb)
  );

  brf_addr_map u_map (
    .mode         (mode_r),
    .in_ram_range (data_in_ram),
    .offset       (data_offset),
    .to_internal  (data_internal),
    .to_external  (data_external),
    .free_bytes   ()
  );

  // ***************************************************************
  // bank write port: spill fill and copies take priority over operands
  // ***************************************************************
  always_comb begin
    ram_we   = op_we && idle;
    ram_wa   = opnd_addr(op_w, mode_r, gbank_r, cbank_r);
    ram_wd   = op_wdata;
    ram_rb_a = idle ? slot_addr(vslot, 4'hF) : slot_addr(slot_r, idx_r); // mask ahead
    case (state_r)
      brf_pkg::ST_LOAD: begin
        ram_we = mem_ack && eff_mask[idx_r];
        ram_wa = slot_addr(slot_r, idx_r);
        ram_wd = mem_rdata;
      end
      brf_pkg::ST_FETCH: begin
        ram_we = mem_ack;                              // register 15 itself
        ram_wa = slot_addr(slot_r, 4'hF);
        ram_wd = mem_rdata;
      end
      brf_pkg::ST_COPY: begin
        ram_rb_a = slot_addr({1'b0, old_gbank_r}, idx_r);
        ram_we   = copy_r[idx_r];
        ram_wa   = slot_addr({1'b0, gmask(mode_r, new_gbank_r)}, idx_r);
        ram_wd   = ram_rb;
      end
      default: begin
      end
    endcase
  end

  // ***************************************************************
  // memory stack bus requests
  // ***************************************************************
  always_comb begin
    mem_out = '0;
    ssp_dec = 1'b0;
    ssp_inc = 1'b0;
    case (state_r)
      brf_pkg::ST_STORE: begin
        mem_out.req   = 1'b1;                          // ascending stores
        mem_out.we    = 1'b1;
        mem_out.addr  = spill_r - brf_pkg::REG_BYTES;
        mem_out.wdata = ram_rb;
      end
      brf_pkg::ST_FETCH: begin
        mem_out.req  = 1'b1;
        mem_out.addr = spill_r;                        // register 15 first
      end
      brf_pkg::ST_LOAD: begin
        mem_out.req  = eff_mask[idx_r] && idx_r != 4'hF;
        mem_out.addr = spill_r;
      end
      brf_pkg::ST_PUSHG: begin
        mem_out.we    = (op_r == brf_pkg::OP_PUSH_CH);
        mem_out.addr  = (op_r == brf_pkg::OP_PUSH_CH) ? supervisor_stack_pointer - brf_pkg::REG_BYTES : supervisor_stack_pointer;
        mem_out.wdata = {28'h0, old_gbank_r};
        mem_out.req   = 1'b1;
        ssp_dec       = mem_ack && (op_r == brf_pkg::OP_PUSH_CH);
        ssp_inc       = mem_ack && (op_r == brf_pkg::OP_PULL);
      end
      default: begin
      end
    endcase
  end

  assign cmd_busy = !idle;

  // ***************************************************************
  // instruction engine
  // ***************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_r     <= brf_pkg::ST_IDLE;
      op_r        <= brf_pkg::OP_NONE;
      idx_r       <= 4'h0;
      mask_r      <= 16'h0000;
      slot_r      <= 5'h00;
      old_gbank_r <= 4'h0;
      new_gbank_r <= 8'h00;
      copy_r      <= 16'h0000;
      priv_fault  <= 1'b0;
      gbank_r     <= brf_pkg::GBANK_RESET;
      cbank_r     <= brf_pkg::CBANK_RESET;
      vlimit_r    <= brf_pkg::VLIMIT_RESET;
      spill_r     <= brf_pkg::SPILL_RESET;
      mode_r      <= brf_pkg::MODE_RESET;
    end else if (ce) begin
      priv_fault <= 1'b0;
      case (state_r)
        brf_pkg::ST_IDLE: begin
          if (reg_wr) begin
            if (reg_addr == brf_pkg::ADDR_MODE) begin
              mode_r <= reg_wdata[4:0];
            end else if (reg_addr == brf_pkg::ADDR_GBANK) begin
              gbank_r <= reg_wdata[7:0];               // active at once
            end else if (reg_addr == brf_pkg::ADDR_CBANK) begin
              cbank_r <= reg_wdata[7:0];
            end else if (reg_addr == brf_pkg::ADDR_VLIMIT) begin
              vlimit_r <= reg_wdata[7:0];
            end else if (reg_addr == brf_pkg::ADDR_SPILL) begin
              spill_r <= reg_wdata;
            end
          end
          if (take) begin
            op_r        <= cmd;
            old_gbank_r <= gmask(mode_r, gbank_r);
            copy_r      <= cmd_copy_mask;
            idx_r       <= 4'h0;
            if (cmd_priv && !supervisor) begin
              priv_fault <= 1'b1;                      // refused outside supervisor
            end else if (cmd == brf_pkg::OP_PUSH_CH) begin
              // immediate or register operand
              new_gbank_r <= cmd_use_reg ? op_a_data[7:0] : {4'h0, cmd_imm};
              state_r     <= brf_pkg::ST_PUSHG;
            end else if (cmd == brf_pkg::OP_PULL) begin
              state_r <= brf_pkg::ST_PUSHG;
            end else if (cmd == brf_pkg::OP_ADVANCE) begin
              // three-bit field wraps
              cbank_r <= {cbank_r[7:3], cbank_r[2:0] + 3'h1};
              if (mode_r[brf_pkg::MODE_RING] && (cbank_r[2:0] + 3'h1) == vlimit_r[2:0]) begin
                slot_r  <= vslot;
                mask_r  <= ram_rb[15:0];               // register 15 of that bank
                state_r <= brf_pkg::ST_STORE;
              end
            end else if (cmd == brf_pkg::OP_RETREAT) begin
              cbank_r <= {cbank_r[7:3], cbank_r[2:0] - 3'h1};
              if (mode_r[brf_pkg::MODE_RING] && (cbank_r[2:0] - 3'h1) == vlimit_r[2:0]
                  && (cbank_r[2:0] - 3'h1) != 3'h0) begin
                vlimit_r <= {vlimit_r[7:3], vlimit_r[2:0] - 3'h1};
                slot_r   <= 5'(brf_pkg::RING_BASE) + {2'h0, vlimit_r[2:0] - 3'h1};
                state_r  <= brf_pkg::ST_FETCH;
              end
            end
          end
        end
        brf_pkg::ST_STORE: begin
          if (!eff_mask[idx_r]) begin
            idx_r <= next_idx;
          end else if (mem_ack) begin
            spill_r <= spill_r - brf_pkg::REG_BYTES;
            if (idx_r == 4'hF) begin
              vlimit_r <= {vlimit_r[7:3], vlimit_r[2:0] + 3'h1};
              state_r  <= brf_pkg::ST_IDLE;
            end else begin
              idx_r <= next_idx;
            end
          end
        end
        brf_pkg::ST_FETCH: begin
          if (mem_ack) begin
            mask_r  <= mem_rdata[15:0];
            idx_r   <= 4'hE;                           // pull back down from register 14
            spill_r <= spill_r + brf_pkg::REG_BYTES;
            state_r <= brf_pkg::ST_LOAD;
          end
        end
        brf_pkg::ST_LOAD: begin
          // descending order mirrors the ascending push, so each word lands home
          if (!eff_mask[idx_r] || mem_ack) begin
            if (eff_mask[idx_r]) begin
              spill_r <= spill_r + brf_pkg::REG_BYTES;
            end
            idx_r <= idx_r - 4'h1;
            if (idx_r == 4'h0) begin
              state_r <= brf_pkg::ST_IDLE;
            end
          end
        end
        brf_pkg::ST_PUSHG: begin
          if (mem_ack) begin
            if (op_r == brf_pkg::OP_PULL) begin
              new_gbank_r <= mem_rdata[7:0];
            end
            state_r <= brf_pkg::ST_COPY;
          end
        end
        brf_pkg::ST_COPY: begin
          if (idx_r == 4'hF) begin
            gbank_r <= new_gbank_r;
            state_r <= brf_pkg::ST_IDLE;
          end else begin
            idx_r <= next_idx;
          end
        end
        default: begin
          state_r <= brf_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // ***************************************************************
  // register read port, data one cycle after the strobe
  // ***************************************************************
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (ce && reg_rd) begin
      if (reg_addr == brf_pkg::ADDR_MODE) begin
        reg_rdata <= {27'h0, mode_r};
      end else if (reg_addr == brf_pkg::ADDR_GBANK) begin
        reg_rdata <= {24'h0, gbank_r};
      end else if (reg_addr == brf_pkg::ADDR_CBANK) begin
        reg_rdata <= {24'h0, cbank_r};
      end else if (reg_addr == brf_pkg::ADDR_VLIMIT) begin
        reg_rdata <= {29'h0, vlimit_r[2:0]};           // upper bits read zero
      end else if (reg_addr == brf_pkg::ADDR_SPILL) begin
        reg_rdata <= spill_r;
      end else if (reg_addr == brf_pkg::ADDR_STATUS) begin
        reg_rdata <= {26'h0, state_r};
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

endmodule
`default_nettype wire

// ### brf_checker.sv
// checker: port assertions for the bank controller
`timescale 1ns/1ps
`default_nettype none
module brf_checker (
  input wire logic                 clock,
  input wire logic                 rst,
  input wire brf_pkg::brf_op_type  cmd,
  input wire logic                 cmd_valid,
  input wire logic                 supervisor,
  input wire logic                 cmd_busy,
  input wire logic                 priv_fault,
  input wire brf_pkg::brf_mem_type mem_out,
  input wire logic                 mem_ack,
  input wire logic                 ssp_dec,
  input wire logic                 ssp_inc,
  input wire logic                 reg_rd,
  input wire logic [3:0]           reg_addr,
  input wire logic [31:0]          reg_rdata
);
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  // a privileged bank command taken at this edge
  sequence bank_cmd_s;
    cmd_valid && !cmd_busy && (cmd == brf_pkg::OP_PUSH_CH || cmd == brf_pkg::OP_PULL);
  endsequence
  user_fault_a: assert property (bank_cmd_s ##0 !supervisor |=> priv_fault)
    else $error("user bank command not refused");
  super_run_a: assert property (bank_cmd_s ##0 supervisor |=> cmd_busy && !priv_fault)
    else $error("supervisor bank command not started");
  req_hold_a: assert property (mem_out.req && !mem_ack |=> mem_out.req && $stable(mem_out.addr))
    else $error("memory request dropped early");
  push_dec_a: assert property (ssp_dec |-> mem_ack && mem_out.we)
    else $error("stack decrement without a store");
  pull_inc_a: assert property (ssp_inc |-> mem_ack && !mem_out.we)
    else $error("stack increment without a load");
  req_busy_a: assert property (mem_out.req |-> cmd_busy)
    else $error("memory request while idle");
  busy_end_a: assert property ($rose(cmd_busy) |-> ##[1:200] !cmd_busy)
    else $error("engine never returned to idle");
  limit_hi_a: assert property (reg_rd && reg_addr == brf_pkg::ADDR_VLIMIT |=> reg_rdata[7:3] == 5'h00)
    else $error("limit upper bits not zero");
endmodule
`default_nettype wire

// ### brf_stack_mem.sv
// stack memory model: supervisor stack pointer and memory answering after a wait
`timescale 1ns/1ps
`default_nettype none
module brf_stack_mem #(parameter int WAIT = 1) (
  input  wire logic                 clock,
  input  wire logic                 rst,
  input  wire brf_pkg::brf_mem_type mem_out,
  input  wire logic                 ssp_dec,
  input  wire logic                 ssp_inc,
  output logic                      mem_ack,
  output logic [31:0]               mem_rdata,
  output logic [31:0]               supervisor_stack_pointer
);
  logic [31:0] mem_r [64];
  int          wait_r;
  wire         take = mem_out.req && !mem_ack && wait_r >= WAIT;
  // ack stands one cycle, so a held request is never answered twice
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_ack <= 1'b0;
      wait_r <= 0;
      supervisor_stack_pointer <= 32'h80;
    end else begin
      mem_ack <= take;
      wait_r <= (mem_out.req && !mem_ack) ? wait_r + 1 : 0;
      supervisor_stack_pointer <= supervisor_stack_pointer - (ssp_dec ? 32'h4 : 32'h0) + (ssp_inc ? 32'h4 : 32'h0);
    end
  end
  // data only with the ack; otherwise a changing pattern so stale reads show
  always_ff @(posedge clock) begin
    if (take && mem_out.we) mem_r[mem_out.addr[7:2]] <= mem_out.wdata;
    mem_rdata <= take ? mem_r[mem_out.addr[7:2]] : ~mem_rdata;
  end
endmodule
`default_nettype wire

// ### testbench.sv
// testbench: register, bank command, ring spill/fill and data window tests
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [3:0] MD = brf_pkg::ADDR_MODE, GB = brf_pkg::ADDR_GBANK;
  localparam logic [3:0] CB = brf_pkg::ADDR_CBANK, VL = brf_pkg::ADDR_VLIMIT;
  logic        clock, cmd_busy, priv_fault, mem_ack, ssp_dec, ssp_inc, data_internal;
  logic        data_external, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, op_we = 1'b0;
  logic        cmd_valid = 1'b0, cmd_use_reg = 1'b0, supervisor = 1'b0, data_in_ram = 1'b0;
  logic [3:0]  reg_addr = 4'h0, cmd_imm = 4'h0;
  logic [15:0] cmd_copy_mask = 16'h0000;
  logic [10:0] data_offset = 11'h37F;
  logic [31:0] reg_wdata = 32'h0, op_wdata = 32'h0, reg_rdata, op_a_data, mem_rdata, supervisor_stack_pointer;
  brf_pkg::brf_operand_type op_a = 6'h00, op_w = 6'h00;
  brf_pkg::brf_op_type      cmd = brf_pkg::OP_NONE;
  brf_pkg::brf_mem_type     mem_out;
  int                       num_errors = 0, n_tests = 0;
  brf_core u_brf_core (.ce(1'b1), .cmd_reg(4'h0), .*);
  brf_stack_mem #(.WAIT(1)) u_brf_stack_mem (.*);
  // 25 MHz clock
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // ************ access tasks ************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask
  // read data appear in the cycle after the strobe and hold until the next read strobe
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk(reg_rdata, e);
    @(posedge clock);
  endtask
  task automatic opw(input logic [1:0] s, input logic [3:0] n, input logic [31:0] d);
    op_w <= {s, n};
    op_wdata <= d;
    op_we <= 1'b1;
    @(posedge clock);
    op_we <= 1'b0;
    @(posedge clock);
  endtask
  // issue one command, then wait a bounded time for the engine to idle
  task automatic go(input brf_pkg::brf_op_type o, input logic s);
    cmd <= o;
    supervisor <= s;
    cmd_valid <= 1'b1;
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(negedge clock);
    for (int n = 0; n < 300 && cmd_busy !== 1'b0; n++) @(negedge clock);
    chk({31'h0, cmd_busy}, 32'h0);
    @(posedge clock);
  endtask
  task automatic win(input logic [31:0] m, input logic e);
    wr(MD, m);
    @(negedge clock);
    chk({31'h0, data_internal}, {31'h0, e});
    @(posedge clock);
  endtask
  task end_sim;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // watchdog: the tests need well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clock);
    num_errors++;
    end_sim;
  end
  // ************ test sequence ************
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(MD, 32'h10);
    wr(4'hF, 32'h5);
    wr(GB, 32'h1);
    rd(GB, 32'h1);
    $display("test registers done");
    wr(MD, 32'h13);
    cmd_imm <= 4'h2;
    go(brf_pkg::OP_PUSH_CH, 1'b0);
    rd(GB, 32'h1);
    go(brf_pkg::OP_PUSH_CH, 1'b1);
    rd(GB, 32'h2);
    opw(brf_pkg::SEL_GLOBAL, 4'h4, 32'h9);
    op_a <= {brf_pkg::SEL_GLOBAL, 4'h4};
    cmd_use_reg <= 1'b1;
    cmd_copy_mask <= 16'h0010;
    go(brf_pkg::OP_PUSH_CH, 1'b1);
    rd(GB, 32'h9);
    @(negedge clock);
    chk(op_a_data, 32'h9);
    @(posedge clock);
    go(brf_pkg::OP_PULL, 1'b1);
    rd(GB, 32'h2);
    $display("test bank commands done");
    wr(MD, 32'h14);
    wr(CB, 32'h0);
    opw(brf_pkg::SEL_CURRENT, 4'h0, 32'h5A);
    opw(brf_pkg::SEL_CURRENT, 4'hF, 32'h3);
    wr(CB, 32'h7);
    wr(VL, 32'h0);
    wr(brf_pkg::ADDR_SPILL, 32'h100);
    go(brf_pkg::OP_ADVANCE, 1'b1);
    rd(CB, 32'h0);
    rd(VL, 32'h1);
    rd(brf_pkg::ADDR_SPILL, 32'hF4);
    opw(brf_pkg::SEL_CURRENT, 4'h0, 32'h0);
    wr(CB, 32'h2);
    go(brf_pkg::OP_RETREAT, 1'b1);
    rd(VL, 32'h0);
    rd(brf_pkg::ADDR_SPILL, 32'h100);
    op_a <= {brf_pkg::SEL_PREV, 4'h0};
    @(negedge clock);
    chk(op_a_data, 32'h5A);
    @(posedge clock);
    go(brf_pkg::OP_RETREAT, 1'b1);
    rd(CB, 32'h0);
    rd(brf_pkg::ADDR_SPILL, 32'h100);
    $display("test ring done");
    data_in_ram <= 1'b1;
    win(32'h10, 1'b1);
    win(32'h18, 1'b0);
    win(32'h00, 1'b0);
    chk({31'h0, data_external}, 32'h1);
    data_offset <= 11'h380;
    win(32'h10, 1'b0);
    $display("test window done");
    end_sim;
  end
endmodule
bind brf_core brf_checker u_brf_checker (.*);
`default_nettype wire
